// ---- shrp_port.sv ----
// file: synchronous host register port top level
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - 8 or 16 bit width, narrow default
// - 128 byte or 64 word locations
// - address captured on edge with select low
// - data registered both directions on rising edge
// - respond only while select low
// - write needs high-low-high write enable
// - drive bus only while select and drive low
// - buffer ready reflects direction and fill
// - irq stays high until cleared
// - irq low while interrupts disabled
// - read data appears two cycles after select
// - back-to-back cycles need no release
// - read buffer holds sixteen 16-bit entries, write path 16 plus a 32-entry skid
// - ready falls two cycles late on reads, one on writes; bad writes dropped
// - irq clear bit drops irq one cycle later
module shrp_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [6:0] host_addr,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  input wire logic host_sel_n,
  input wire logic host_wr_n,
  input wire logic host_rd_drive_n,
  input wire logic irq_event,
  output logic buffer_ready,
  output logic irq_out,
  output logic [15:0] stream_data,
  output logic stream_valid,
  input wire logic stream_ready,
  input wire logic [15:0] fill_data,
  input wire logic fill_valid,
  output logic fill_ready
);
  ////////////////////////////////////////////////////////////////////
  // registered host pins; host clocks this block, so no synchroniser
  shrp_pkg::shrp_pins_s s2_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s2_reg <= '{sel_n: 1'b1, wr_n: 1'b1, rd_drive_n: 1'b1, addr: '0, data: '0};
    end else begin
      s2_reg <= '{sel_n: host_sel_n, wr_n: host_wr_n, rd_drive_n: host_rd_drive_n,
                  addr: host_addr, data: host_data_in};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address capture and write sequence
  logic [6:0] addr_reg;
  logic [15:0] wdata_reg;
  logic wide_reg;
  logic [5:0] widx;
  logic [15:0] ctrl_reg;
  shrp_pkg::shrp_wr_e wr_state_reg;
  logic wr_commit;
  logic wr_low_ok;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= '0;
    end else if (!host_sel_n) begin
      addr_reg <= host_addr;
    end
  end

  // word index: 64 words wide, 128 bytes narrow
  assign widx = wide_reg ? addr_reg[5:0] : addr_reg[6:1];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_state_reg <= shrp_pkg::SHRP_WR_IDLE;
      wdata_reg <= '0;
      wr_low_ok <= 1'b0;
    end else begin
      case (wr_state_reg)
        shrp_pkg::SHRP_WR_IDLE: begin
          if (!s2_reg.sel_n && s2_reg.wr_n) begin
            wr_state_reg <= shrp_pkg::SHRP_WR_LOW;
          end
        end
        shrp_pkg::SHRP_WR_LOW: begin
          if (s2_reg.sel_n) begin
            wr_state_reg <= shrp_pkg::SHRP_WR_IDLE;
          end else if (!s2_reg.wr_n) begin
            wdata_reg <= s2_reg.data;
            wr_low_ok <= buffer_ready;
            wr_state_reg <= shrp_pkg::SHRP_WR_DONE;
          end
        end
        shrp_pkg::SHRP_WR_DONE: begin
          // select may already be released in the closing high cycle
          if (!s2_reg.sel_n && s2_reg.wr_n) begin
            wr_state_reg <= shrp_pkg::SHRP_WR_LOW;
          end else begin
            wr_state_reg <= shrp_pkg::SHRP_WR_IDLE;
          end
        end
        default: wr_state_reg <= shrp_pkg::SHRP_WR_IDLE;
      endcase
    end
  end

  assign wr_commit = (wr_state_reg == shrp_pkg::SHRP_WR_DONE) && s2_reg.wr_n;

  ////////////////////////////////////////////////////////////////////
  // bus mode and control registers
  logic narrow_hi;
  assign narrow_hi = addr_reg[0];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wide_reg <= shrp_pkg::BUSMODE_RST;
      ctrl_reg <= shrp_pkg::CTRL_RST;
    end else if (wr_commit) begin
      if (widx == shrp_pkg::BUSMODE_IDX) begin
        wide_reg <= wdata_reg[0];
      end else if (widx == shrp_pkg::CTRL_IDX) begin
        if (wide_reg) begin
          ctrl_reg <= wdata_reg;
        end else if (narrow_hi) begin
          ctrl_reg[15:8] <= wdata_reg[7:0];
        end else begin
          ctrl_reg[7:0] <= wdata_reg[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transfer buffer: 16-entry read side; write side 16 entries plus a 32-entry skid
  logic buf_dir;
  logic buf_wr_push;
  logic buf_rd_pop;
  logic rd_valid;
  logic wr_space;
  logic [15:0] rd_word;
  logic [4:0] wr_level;
  logic [15:0] out_word;
  logic out_valid;
  logic out_ready;
  assign buf_dir = ctrl_reg[shrp_pkg::BUF_DIR_POS];
  assign buf_wr_push = wr_commit && wr_low_ok && buf_dir && (widx == shrp_pkg::BUF_IDX);
  logic rd_active;
  assign rd_active = !s2_reg.sel_n && !s2_reg.rd_drive_n && (widx == shrp_pkg::BUF_IDX);
  logic rd_active_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_active_q <= 1'b0;
    end else begin
      rd_active_q <= rd_active;
    end
  end
  assign buf_rd_pop = rd_active && !rd_active_q && !buf_dir && rd_valid;

  shrp_fifo #(.WIDTH(shrp_pkg::BUF_W), .DEPTH(shrp_pkg::BUF_DEPTH)) u_rdbuf (
    .clock(clock), .rst_b(rst_b),
    .in_valid(fill_valid), .in_ready(fill_ready), .in_data(fill_data),
    .out_valid(rd_valid), .out_ready(buf_rd_pop), .out_data(rd_word), .level());

  shrp_fifo #(.WIDTH(shrp_pkg::BUF_W), .DEPTH(shrp_pkg::BUF_DEPTH)) u_wrbuf (
    .clock(clock), .rst_b(rst_b),
    .in_valid(buf_wr_push), .in_ready(wr_space), .in_data(wdata_reg),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_word), .level(wr_level));

  shrp_fifo #(.WIDTH(shrp_pkg::BUF_W), .DEPTH(shrp_pkg::SKID_DEPTH)) u_skid (
    .clock(clock), .rst_b(rst_b),
    .in_valid(out_valid), .in_ready(out_ready), .in_data(out_word),
    .out_valid(stream_valid), .out_ready(stream_ready), .out_data(stream_data),
    .level());

  // ready lags drain/fill by the pipeline depth; a write-side fill drops it after one cycle
  logic brdy_d_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      brdy_d_reg <= 1'b0;
      buffer_ready <= 1'b0;
    end else begin
      brdy_d_reg <= buf_dir ? (wr_space && wr_level != 5'h0F) || (!buf_wr_push && wr_space)
                            : rd_valid;
      buffer_ready <= brdy_d_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt
  logic irq_pend_reg;
  logic clr_d_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_pend_reg <= 1'b0;
      clr_d_reg <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      clr_d_reg <= ctrl_reg[shrp_pkg::IRQ_CLR_POS];
      if (irq_event) begin
        irq_pend_reg <= 1'b1;
      end else if (clr_d_reg) begin
        irq_pend_reg <= 1'b0;
      end
      irq_out <= irq_pend_reg && ctrl_reg[shrp_pkg::IRQ_EN_POS]
                 && !ctrl_reg[shrp_pkg::IRQ_CLR_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data path and drive
  logic [15:0] rword;
  always_comb begin
    rword = 16'h0000;
    case (widx)
      shrp_pkg::BUSMODE_IDX: rword = {15'h0000, wide_reg};
      shrp_pkg::STATUS_IDX: rword = {10'h000, wr_state_reg, buf_dir, irq_pend_reg,
                                     buffer_ready, rd_valid};
      shrp_pkg::CTRL_IDX: rword = ctrl_reg;
      shrp_pkg::BUF_IDX: rword = rd_word;
      default: rword = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_data_out <= '0;
      host_data_oe <= 1'b0;
    end else begin
      if (wide_reg) begin
        host_data_out <= rword;
      end else begin
        host_data_out <= {8'h00, narrow_hi ? rword[15:8] : rword[7:0]};
      end
      host_data_oe <= !host_sel_n && !host_rd_drive_n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  cmt_a: assert property (@(posedge clock) disable iff (!rst_b)
    host_sel_n |=> !host_data_oe) else $error("bus driven while deselected");
  irqdis_a: assert property (@(posedge clock) disable iff (!rst_b)
    !$past(ctrl_reg[shrp_pkg::IRQ_EN_POS]) |-> !irq_out) else $error("irq while disabled");
  sequence wr_seq;
    !s2_reg.sel_n && s2_reg.wr_n ##1 !s2_reg.sel_n && !s2_reg.wr_n;
  endsequence
  wrseq_a: assert property (@(posedge clock) disable iff (!rst_b)
    wr_commit |-> !$past(s2_reg.wr_n) && $past(s2_reg.wr_n, 2)) else $error("bad write");
  nosel_a: assert property (@(posedge clock) disable iff (!rst_b)
    s2_reg.sel_n && (wr_state_reg != shrp_pkg::SHRP_WR_DONE) |=> $stable(ctrl_reg))
    else $error("register written while deselected");
  addr_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    host_sel_n |=> $stable(addr_reg)) else $error("address moved");
  irqclr_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(ctrl_reg[shrp_pkg::IRQ_CLR_POS]) |=> !irq_out) else $error("irq not cleared");
  wrpush_a: assert property (@(posedge clock) disable iff (!rst_b)
    wr_seq ##1 (wr_commit && !wr_low_ok) |=> (wr_level <= $past(wr_level)))
    else $error("full write stored");
  mode_a: assert property (@(posedge clock) disable iff (!rst_b)
    !wr_commit |=> $stable(wide_reg)) else $error("width changed");
endmodule
`default_nettype wire

// ---- shrp_pkg.sv ----
// package: constants and carriers for the synchronous host register port
package shrp_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int BUF_DEPTH = 16;
  localparam int BUF_W = 16;
  localparam int SKID_DEPTH = 32;
  // word indices (16-bit view) of modelled registers
  localparam logic [5:0] BUSMODE_IDX = 6'h00;
  localparam logic [5:0] STATUS_IDX = 6'h02;
  localparam logic [5:0] CTRL_IDX = 6'h0C;
  localparam logic [5:0] BUF_IDX = 6'h20;
  localparam int IRQ_CLR_POS = 11;
  localparam int IRQ_EN_POS = 8;
  localparam int BUF_DIR_POS = 0;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic BUSMODE_RST = 1'b0;
  localparam int DATA_LAT_CYC = 2;
  localparam int BRDY_LAG_CYC = 2;
  localparam int IRQ_CLR_LAG_CYC = 2;

  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic rd_drive_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } shrp_pins_s;

  typedef enum logic [1:0] {
    SHRP_WR_IDLE = 2'b00,
    SHRP_WR_LOW = 2'b01,
    SHRP_WR_DONE = 2'b10
  } shrp_wr_e;
endpackage

// ---- shrp_fifo.sv ----
// file: parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module shrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_reg];
  assign level = cnt_reg;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- shrp_host_model.sv ----
// file: host bus model driving the port pins
`timescale 1ns/10ps
`default_nettype none
module shrp_host_model (
  input wire logic clock,
  output logic [6:0] host_addr,
  output logic [15:0] host_data_in,
  output logic host_sel_n,
  output logic host_wr_n,
  output logic host_rd_drive_n,
  input wire logic [15:0] host_data_out,
  input wire logic host_data_oe
);
  initial begin
    host_addr = 7'h55;
    host_data_in = 16'h5A5A;
    host_sel_n = 1'b1;
    host_wr_n = 1'b1;
    host_rd_drive_n = 1'b1;
  end
  // released lines show the inverse of the last value
  task automatic rel;
    host_addr <= ~host_addr;
    host_data_in <= ~host_data_in;
  endtask
  // select, strobe low with data, strobe high
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic sel);
    @(posedge clock);
    host_addr <= a;
    host_sel_n <= sel;
    host_wr_n <= 1'b1;
    host_rd_drive_n <= 1'b1;
    @(posedge clock);
    host_wr_n <= 1'b0;
    host_data_in <= d;
    @(posedge clock);
    host_wr_n <= 1'b1;
    repeat (2) @(posedge clock);
    host_sel_n <= 1'b1;
    rel();
  endtask
  // two writes without releasing select between them
  task automatic wr2(input logic [6:0] a, input logic [15:0] d0, input logic [15:0] d1);
    @(posedge clock);
    host_addr <= a;
    host_sel_n <= 1'b0;
    host_wr_n <= 1'b1;
    host_rd_drive_n <= 1'b1;
    @(posedge clock);
    host_wr_n <= 1'b0;
    host_data_in <= d0;
    @(posedge clock);
    host_wr_n <= 1'b1;
    @(posedge clock);
    host_wr_n <= 1'b0;
    host_data_in <= d1;
    @(posedge clock);
    host_wr_n <= 1'b1;
    repeat (2) @(posedge clock);
    host_sel_n <= 1'b1;
    rel();
  endtask
  // select with strobe high, drive low in cycle 2, released in cycle 3
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
    int n;
    @(posedge clock);
    host_addr <= a;
    host_sel_n <= 1'b0;
    host_wr_n <= 1'b1;
    repeat (2) @(posedge clock);
    host_rd_drive_n <= 1'b0;
    @(posedge clock);
    host_rd_drive_n <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (host_data_oe !== 1'b1 && n < 8);
    d = host_data_out;
    ok = (n == 1);
    host_sel_n <= 1'b1;
    rel();
  endtask
endmodule
`default_nettype wire

// ---- shrp_port_test.sv ----
// file: self-checking testbench of the host register port
`timescale 1ns/10ps
`default_nettype none
module shrp_port_test;
  logic clock, rst_b, irq_event, stream_ready, fill_valid, ok;
  logic [15:0] fill_data, host_data_out, stream_data, host_data_in, rv;
  logic [6:0] host_addr;
  logic host_data_oe, host_sel_n, host_wr_n, host_rd_drive_n;
  logic buffer_ready, irq_out, stream_valid, fill_ready;
  int miscompares, checked, n;
  shrp_port dut_u (.clock(clock), .rst_b(rst_b), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .host_sel_n(host_sel_n), .host_wr_n(host_wr_n), .host_rd_drive_n(host_rd_drive_n),
    .irq_event(irq_event), .buffer_ready(buffer_ready), .irq_out(irq_out),
    .stream_data(stream_data), .stream_valid(stream_valid), .stream_ready(stream_ready),
    .fill_data(fill_data), .fill_valid(fill_valid), .fill_ready(fill_ready));
  shrp_host_model hm_u (.clock(clock), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_sel_n(host_sel_n), .host_wr_n(host_wr_n), .host_rd_drive_n(host_rd_drive_n),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // read, check data under mask, then bus released within four cycles
  task automatic rdc(input logic [6:0] a, input logic [15:0] m, input logic [15:0] exp);
    hm_u.rd(a, rv, ok);
    chk("read answered", {15'h0000, ok}, 16'h0001);
    chk("read data", rv & m, exp);
    repeat (4) @(posedge clock);
    chk("bus released", {15'h0000, host_data_oe}, 16'h0000);
  endtask
  task automatic pulse_irq;
    @(posedge clock);
    irq_event <= 1'b1;
    @(posedge clock);
    irq_event <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("irq after reset", {15'h0000, irq_out}, 16'h0000);
    chk("oe after reset", {15'h0000, host_data_oe}, 16'h0000);
    rdc(7'h00, 16'h00FF, 16'h0000);
    rdc(7'h19, 16'h00FF, 16'h0000);
  endtask
  task automatic t_irq;
    pulse_irq();
    chk("irq while disabled", {15'h0000, irq_out}, 16'h0000);
    hm_u.wr(7'h19, 16'h0001, 1'b0);
    rdc(7'h19, 16'h00FF, 16'h0001);
    rdc(7'h18, 16'h00FF, 16'h0000);
    pulse_irq();
    repeat (10) begin
      @(posedge clock);
      chk("irq held", {15'h0000, irq_out}, 16'h0001);
    end
    hm_u.wr(7'h19, 16'h0009, 1'b0);
    n = 0;
    while (irq_out !== 1'b0 && n < 6) begin
      @(posedge clock);
      n++;
    end
    chk("irq cleared in time", {15'h0000, irq_out}, 16'h0000);
    hm_u.wr(7'h19, 16'h0000, 1'b0);
  endtask
  task automatic t_ignore;
    hm_u.wr(7'h19, 16'h00FF, 1'b1);
    rdc(7'h19, 16'h00FF, 16'h0000);
    hm_u.wr(7'h18, 16'h00FF, 1'b1);
    rdc(7'h18, 16'h00FF, 16'h0000);
  endtask
  task automatic t_width;
    hm_u.wr(7'h00, 16'h0001, 1'b0);
    rdc(7'h00, 16'hFFFF, 16'h0001);
    hm_u.wr(7'h00, 16'h0000, 1'b0);
    rdc(7'h00, 16'h00FF, 16'h0000);
  endtask
  task automatic t_buf;
    n = 0;
    fill_valid <= 1'b1;
    fill_data <= 16'hA000;
    repeat (60) begin
      @(posedge clock);
      if (fill_ready === 1'b1) begin
        n++;
        fill_data <= 16'hA000 + n[15:0];
      end
    end
    fill_valid <= 1'b0;
    chk("fill refused", {15'h0000, fill_ready}, 16'h0000);
    chk("ready when filled", {15'h0000, buffer_ready}, 16'h0001);
    hm_u.wr(7'h00, 16'h0001, 1'b0);
    for (int k = 0; k < n; k++) begin
      rdc(7'h20, 16'hFFFF, 16'hA000 + k[15:0]);
    end
    repeat (4) @(posedge clock);
    chk("ready when drained", {15'h0000, buffer_ready}, 16'h0000);
    hm_u.wr(7'h00, 16'h0000, 1'b0);
  endtask
  task automatic t_wbuf;
    stream_ready <= 1'b0;
    hm_u.wr(7'h00, 16'h0001, 1'b0);
    hm_u.wr(7'h0C, 16'h0001, 1'b0);
    rdc(7'h0C, 16'hFFFF, 16'h0001);
    chk("ready for writes", {15'h0000, buffer_ready}, 16'h0001);
    hm_u.wr(7'h20, 16'hB000, 1'b0);
    hm_u.wr2(7'h20, 16'hB001, 16'hB002);
    for (int k = 0; k < 3; k++) begin
      chk("stream valid", {15'h0000, stream_valid}, 16'h0001);
      chk("stream data", stream_data, 16'hB000 + k[15:0]);
      stream_ready <= 1'b1;
      @(posedge clock);
      stream_ready <= 1'b0;
      @(posedge clock);
    end
    chk("stream empty", {15'h0000, stream_valid}, 16'h0000);
    stream_ready <= 1'b1;
    hm_u.wr(7'h0C, 16'h0000, 1'b0);
    hm_u.wr(7'h00, 16'h0000, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    end_sim();
  end
  initial begin
    miscompares = 0;
    checked = 0;
    rst_b = 1'b0;
    irq_event = 1'b0;
    stream_ready = 1'b1;
    fill_valid = 1'b0;
    fill_data = 16'h0000;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_irq();
    t_ignore();
    t_width();
    t_buf();
    t_wbuf();
    end_sim();
  end
endmodule
`default_nettype wire
